// ---- hw/urd_decoder.sv ----
// usb bus resistor decoder with an axi4-lite register slave
//////////////////////////////////////////////////////////////////////////////
//
// The address map and the AXI4-Lite slave port were left to the implementer.

module urd_decoder
   import urd_pkg::*;
(
   // clock, reset, enable
   input  wire  logic                  clk_i,
   input  wire  logic                  rst_i,
   input  wire  logic                  ce_i,
   // axi4-lite write address
   input  wire  logic                  s_axi_awvalid,
   output logic                        s_axi_awready,
   input  wire  logic [URD_ADDR_W-1:0] s_axi_awaddr,
   // axi4-lite write data
   input  wire  logic                  s_axi_wvalid,
   output logic                        s_axi_wready,
   input  wire  logic [URD_DATA_W-1:0] s_axi_wdata,
   input  wire  logic [3:0]            s_axi_wstrb,
   // axi4-lite write response
   output logic                        s_axi_bvalid,
   input  wire  logic                  s_axi_bready,
   output logic [1:0]                  s_axi_bresp,
   // axi4-lite read address
   input  wire  logic                  s_axi_arvalid,
   output logic                        s_axi_arready,
   input  wire  logic [URD_ADDR_W-1:0] s_axi_araddr,
   // axi4-lite read data
   output logic                        s_axi_rvalid,
   input  wire  logic                  s_axi_rready,
   output logic [URD_DATA_W-1:0]       s_axi_rdata,
   output logic [1:0]                  s_axi_rresp,
   // resistor enables toward the analog front end
   output urd_res_t                    resistor_en_o
);

   ////////////////////////////////////////////////////////////////////////////
   // whole block state in one record
   typedef struct packed {
      urd_ctrl_t             ctrl;
      urd_res_t              res;
      logic                  aw_got;
      logic [URD_ADDR_W-1:0] aw_addr;
      logic                  w_got;
      logic [URD_CTRL_W-1:0] w_data;
      logic                  w_lane0;
      logic                  awready;
      logic                  wready;
      logic                  bvalid;
      logic [1:0]            bresp;
      logic                  arready;
      logic                  rvalid;
      logic [1:0]            rresp;
      logic [URD_DATA_W-1:0] rdata;
   } urd_state_t;

   urd_state_t st_r;
   urd_state_t st_nxt;
   logic       wr_fire;
   logic       rd_fire;

   ////////////////////////////////////////////////////////////////////////////
   // field decode: non-driving mode overrides every other field
   function automatic urd_res_t urd_decode(input urd_ctrl_t c);
      urd_res_t r;
      logic     drive;
      drive = (c.operating_mode_field != URD_OPM_NONDRIVE);
      r.dplus_pulldown_enable  = c.dplus_pulldown_request  & drive;
      r.dminus_pulldown_enable = c.dminus_pulldown_request & drive;
      r.dplus_pullup_enable    = c.termination_select
                               & ~c.dplus_pulldown_request & drive;
      r.highspeed_termination_enable =
         (c.transceiver_speed_select == URD_XCVR_HS)
         & ~c.termination_select & drive;
      // resume and test j/k rows fall out of the same four equations
      return r;
   endfunction

   // a write completes once both address and data are held
   assign wr_fire = st_r.aw_got & st_r.w_got & ~st_r.bvalid;
   // a read is taken only while no read data is pending
   assign rd_fire = s_axi_arvalid & st_r.arready;

   ////////////////////////////////////////////////////////////////////////////
   // next-state logic
   always_comb begin
      st_nxt = st_r;

      // address and data may arrive in either order, each held until used
      if (s_axi_awvalid && st_r.awready) begin
         st_nxt.aw_got  = 1'b1;
         st_nxt.aw_addr = s_axi_awaddr;
      end
      if (s_axi_wvalid && st_r.wready) begin
         st_nxt.w_got   = 1'b1;
         st_nxt.w_data  = s_axi_wdata[URD_CTRL_W-1:0];
         st_nxt.w_lane0 = s_axi_wstrb[0];
      end

      // commit the write; only byte lane 0 carries control bits
      if (wr_fire) begin
         st_nxt.aw_got = 1'b0;
         st_nxt.w_got  = 1'b0;
         st_nxt.bvalid = 1'b1;
         if (st_r.aw_addr == URD_OFS_CTRL) begin
            st_nxt.bresp = URD_RESP_OKAY;
            if (st_r.w_lane0) begin
               st_nxt.ctrl = urd_ctrl_t'(st_r.w_data);
            end
         end else if (st_r.aw_addr == URD_OFS_STATUS) begin
            st_nxt.bresp = URD_RESP_OKAY;                                 // read-only, write dropped
         end else begin
            st_nxt.bresp = URD_RESP_SLVERR;
         end
      end else if (st_r.bvalid && s_axi_bready) begin
         st_nxt.bvalid = 1'b0;
      end

      // ready stays low while the slot is full or a response waits
      st_nxt.awready = ~st_nxt.aw_got & ~st_nxt.bvalid;
      st_nxt.wready  = ~st_nxt.w_got  & ~st_nxt.bvalid;

      // read path: one outstanding read, answered the cycle after it is taken
      if (rd_fire) begin
         st_nxt.rvalid = 1'b1;
         st_nxt.rdata  = '0;
         if (s_axi_araddr == URD_OFS_CTRL) begin
            st_nxt.rresp = URD_RESP_OKAY;
            st_nxt.rdata[URD_CTRL_W-1:0] = st_r.ctrl;
         end else if (s_axi_araddr == URD_OFS_STATUS) begin
            st_nxt.rresp = URD_RESP_OKAY;
            st_nxt.rdata[URD_RES_W-1:0] = st_r.res;
         end else begin
            st_nxt.rresp = URD_RESP_SLVERR;
         end
      end else if (st_r.rvalid && s_axi_rready) begin
         st_nxt.rvalid = 1'b0;
      end
      st_nxt.arready = ~st_nxt.rvalid;

      // enables follow the fields; registered so the pins never glitch
      st_nxt.res = urd_decode(st_r.ctrl);
   end

   ////////////////////////////////////////////////////////////////////////////
   // state register; clock enable freezes everything except reset
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         st_r         <= '0;
         st_r.ctrl    <= URD_CTRL_RST;
         st_r.res     <= URD_RES_RST;
         st_r.awready <= 1'b1;
         st_r.wready  <= 1'b1;
         st_r.arready <= 1'b1;
      end else if (ce_i) begin
         st_r <= st_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // outputs straight from the state register
   assign s_axi_awready = st_r.awready;
   assign s_axi_wready  = st_r.wready;
   assign s_axi_bvalid  = st_r.bvalid;
   assign s_axi_bresp   = st_r.bresp;
   assign s_axi_arready = st_r.arready;
   assign s_axi_rvalid  = st_r.rvalid;
   assign s_axi_rdata   = st_r.rdata;
   assign s_axi_rresp   = st_r.rresp;
   assign resistor_en_o = st_r.res;

   ////////////////////////////////////////////////////////////////////////////
   // checks
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);

   // helper views of the current fields
   urd_ctrl_t c;
   assign c = st_r.ctrl;

   // a control write that carries lane 0
   sequence s_ctrl_write;
      ce_i && wr_fire && st_r.aw_addr == URD_OFS_CTRL && st_r.w_lane0;
   endsequence

   // the written value is in the fields right after the commit
   sequence s_fields_land;
      c == urd_ctrl_t'($past(st_r.w_data));
   endsequence

   chk_ctrl_write_load: assert property (
      s_ctrl_write |=> s_fields_land)
      else $error("control write not taken into fields");

   chk_enables_follow: assert property (
      ce_i |=> resistor_en_o == urd_decode($past(c)))
      else $error("resistor enables do not follow fields");

   chk_pullup_cause: assert property (
      ce_i ##1 resistor_en_o.dplus_pullup_enable |->
         $past(c.termination_select) && !$past(c.dplus_pulldown_request))
      else $error("pull-up on without termination select");

   chk_dplus_pulldown_request: assert property (
      ce_i |=> resistor_en_o.dplus_pulldown_enable ==
         ($past(c.dplus_pulldown_request)
          && $past(c.operating_mode_field) != URD_OPM_NONDRIVE))
      else $error("positive pull-down mismatch");

   chk_dminus_pulldown_request: assert property (
      ce_i |=> resistor_en_o.dminus_pulldown_enable ==
         ($past(c.dminus_pulldown_request)
          && $past(c.operating_mode_field) != URD_OPM_NONDRIVE))
      else $error("negative pull-down mismatch");

   chk_nondrive_off: assert property (
      ce_i && c.operating_mode_field == URD_OPM_NONDRIVE |=> resistor_en_o == '0)
      else $error("enables on in non-driving mode");

   chk_host_resume: assert property (
      ce_i && c == urd_ctrl_t'({1'b1, 1'b1, URD_OPM_NOSTUFF, 1'b1, URD_XCVR_FS}) |=>
         resistor_en_o == urd_res_t'({1'b0, 1'b1, 1'b1, 1'b0}))
      else $error("host resume enables wrong");

   chk_host_testjk: assert property (
      ce_i && c == urd_ctrl_t'({1'b1, 1'b1, URD_OPM_NOSTUFF, 1'b0, URD_XCVR_HS}) |=>
         resistor_en_o == urd_res_t'({1'b1, 1'b1, 1'b1, 1'b0}))
      else $error("host test j/k enables wrong");

   chk_periph_testjk: assert property (
      ce_i && c == urd_ctrl_t'({1'b0, 1'b0, URD_OPM_NOSTUFF, 1'b0, URD_XCVR_HS}) |=>
         resistor_en_o == urd_res_t'({1'b1, 1'b0, 1'b0, 1'b0}))
      else $error("peripheral test j/k enables wrong");

   chk_pullup_exact: assert property (
      ce_i |=> resistor_en_o.dplus_pullup_enable ==
         ($past(c.termination_select) && !$past(c.dplus_pulldown_request)
          && $past(c.operating_mode_field) != URD_OPM_NONDRIVE))
      else $error("pull-up enable mismatch");

   chk_hsterm_exact: assert property (
      ce_i |=> resistor_en_o.highspeed_termination_enable ==
         ($past(c.transceiver_speed_select) == URD_XCVR_HS
          && !$past(c.termination_select)
          && $past(c.operating_mode_field) != URD_OPM_NONDRIVE))
      else $error("termination enable mismatch");

   // response and read data hold until taken
   chk_bvalid_hold: assert property (
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped early");

   chk_rvalid_hold: assert property (
      s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data dropped early");

   chk_write_answer: assert property (
      s_ctrl_write |=> s_axi_bvalid && s_axi_bresp == URD_RESP_OKAY)
      else $error("no response one cycle after write");

   chk_rresp_hold: assert property (
      s_axi_rvalid && !s_axi_rready |=> $stable(s_axi_rresp))
      else $error("read response changed while waiting");

   chk_ready_return: assert property (
      ce_i && s_axi_bvalid && s_axi_bready |=> s_axi_awready && s_axi_wready)
      else $error("write ready not back after response");

   chk_arready_return: assert property (
      ce_i && s_axi_rvalid && s_axi_rready |=> s_axi_arready)
      else $error("read ready not back after data taken");

   ////////////////////////////////////////////////////////////////////////////
   // clock enable low must freeze every register, bus side included
   chk_freeze_fields: assert property (
      !ce_i |=> $stable(c) && $stable(resistor_en_o))
      else $error("fields or enables moved while frozen");

   chk_freeze_bus: assert property (
      !ce_i |=> $stable(s_axi_bvalid) && $stable(s_axi_rvalid)
         && $stable(s_axi_awready) && $stable(s_axi_arready))
      else $error("bus state moved while frozen");

   // responses and ready signals never overlap on one channel
   chk_write_refuse: assert property (
      s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write ready while a response waits");

   chk_read_refuse: assert property (
      s_axi_rvalid |-> !s_axi_arready)
      else $error("read ready while read data waits");

   // a read taken while the clock enable is high is answered at the very next clock edge
   sequence s_read_taken;
      ce_i && s_axi_arvalid && s_axi_arready;
   endsequence

   chk_read_answer: assert property (
      s_read_taken |=> s_axi_rvalid)
      else $error("no read data one cycle after address");

   chk_status_read: assert property (
      s_read_taken ##0 s_axi_araddr == URD_OFS_STATUS |=>
         s_axi_rdata[URD_RES_W-1:0] == $past(resistor_en_o)
         && s_axi_rdata[URD_DATA_W-1:URD_RES_W] == '0 && s_axi_rresp == URD_RESP_OKAY)
      else $error("status read does not show the enables");

   chk_ctrl_read: assert property (
      s_read_taken ##0 s_axi_araddr == URD_OFS_CTRL |=>
         s_axi_rdata[URD_CTRL_W-1:0] == $past(c) && s_axi_rresp == URD_RESP_OKAY)
      else $error("control read does not show the fields");

   chk_read_unmapped: assert property (
      s_read_taken ##0 (s_axi_araddr != URD_OFS_CTRL && s_axi_araddr != URD_OFS_STATUS)
         |=> s_axi_rresp == URD_RESP_SLVERR && s_axi_rdata == '0)
      else $error("unmapped read not refused");

   // a write to any other place leaves the fields as they were
   sequence s_write_commit;
      ce_i && wr_fire;
   endsequence

   chk_masked_write: assert property (
      s_write_commit ##0 (st_r.aw_addr != URD_OFS_CTRL || !st_r.w_lane0) |=> $stable(c))
      else $error("fields changed without a lane 0 control write");

   chk_write_unmapped: assert property (
      s_write_commit ##0 (st_r.aw_addr != URD_OFS_CTRL && st_r.aw_addr != URD_OFS_STATUS)
         |=> s_axi_bresp == URD_RESP_SLVERR)
      else $error("unmapped write not refused");

   // reset lands whatever the enable does
   chk_reset_state: assert property (disable iff (1'b0)
      rst_i |=> c == URD_CTRL_RST && resistor_en_o == URD_RES_RST
         && !s_axi_bvalid && !s_axi_rvalid)
      else $error("reset state wrong");

endmodule // urd_decoder

// ---- hw/urd_pkg.sv ----
// package for the usb bus resistor decoder: register map, field layout, types
package urd_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // bus geometry
   localparam int unsigned URD_ADDR_W = 4;
   localparam int unsigned URD_DATA_W = 32;

   // register byte offsets
   localparam logic [URD_ADDR_W-1:0] URD_OFS_CTRL   = 4'h0;
   localparam logic [URD_ADDR_W-1:0] URD_OFS_STATUS = 4'h4;

   // axi responses
   localparam logic [1:0] URD_RESP_OKAY   = 2'h0;
   localparam logic [1:0] URD_RESP_SLVERR = 2'h2;

   ////////////////////////////////////////////////////////////////////////////
   // operating-mode and transceiver-select encodings
   localparam logic [1:0] URD_OPM_NORMAL   = 2'h0;
   localparam logic [1:0] URD_OPM_NONDRIVE = 2'h1;
   localparam logic [1:0] URD_OPM_NOSTUFF  = 2'h2;
   localparam logic [1:0] URD_XCVR_HS      = 2'h0;
   localparam logic [1:0] URD_XCVR_FS      = 2'h1;
   localparam logic [1:0] URD_XCVR_LS      = 2'h2;

   // control register layout, low bits of the word (bit 6 down to bit 0)
   typedef struct packed {
      logic       dminus_pulldown_request;   // bit 6
      logic       dplus_pulldown_request;    // bit 5
      logic [1:0] operating_mode_field;      // bits 4:3
      logic       termination_select;        // bit 2
      logic [1:0] transceiver_speed_select;  // bits 1:0
   } urd_ctrl_t;

   localparam int unsigned URD_CTRL_W = $bits(urd_ctrl_t);

   // status register layout: resistor enables (bit 3 down to bit 0)
   typedef struct packed {
      logic highspeed_termination_enable;    // bit 3
      logic dminus_pulldown_enable;          // bit 2
      logic dplus_pulldown_enable;           // bit 1
      logic dplus_pullup_enable;             // bit 0
   } urd_res_t;

   localparam int unsigned URD_RES_W = $bits(urd_res_t);

   // power-up signalling state: full-speed select, both pull-downs requested
   localparam urd_ctrl_t URD_CTRL_RST = '{
      dminus_pulldown_request:  1'b1,
      dplus_pulldown_request:   1'b1,
      operating_mode_field:     URD_OPM_NORMAL,
      termination_select:       1'b0,
      transceiver_speed_select: URD_XCVR_FS
   };

   localparam urd_res_t URD_RES_RST = '{
      highspeed_termination_enable: 1'b0,
      dminus_pulldown_enable:       1'b1,
      dplus_pulldown_enable:        1'b1,
      dplus_pullup_enable:          1'b0
   };

endpackage : urd_pkg

// ---- testbench/urd_link_model.sv ----
// link-side model: axi4-lite master that programs the decoder registers
module urd_link_model
   import urd_pkg::*;
(
   // clock
   input  wire logic                  clk_i,
   // write channels
   output logic                       awvalid_o,
   input  wire logic                  awready_i,
   output logic [URD_ADDR_W-1:0]      awaddr_o,
   output logic                       wvalid_o,
   input  wire logic                  wready_i,
   output logic [URD_DATA_W-1:0]      wdata_o,
   output logic [3:0]                 wstrb_o,
   input  wire logic                  bvalid_i,
   output logic                       bready_o,
   input  wire logic [1:0]            bresp_i,
   // read channels
   output logic                       arvalid_o,
   input  wire logic                  arready_i,
   output logic [URD_ADDR_W-1:0]      araddr_o,
   input  wire logic                  rvalid_i,
   output logic                       rready_o,
   input  wire logic [URD_DATA_W-1:0] rdata_i,
   input  wire logic [1:0]            rresp_i
);
   timeunit 1ns;
   timeprecision 1ns;

   ////////////////////////////////////////////////////////////////////////////
   // idle bus at time zero
   initial begin
      {awvalid_o, wvalid_o, bready_o, arvalid_o, rready_o} = 5'h00;
      {awaddr_o, araddr_o, wstrb_o} = 12'h000;
      wdata_o = 32'h00000000;
   end

   // every field value after reset comes from the link; the decoder only picks the reset value URD_CTRL_RST
   task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s,
                     output logic [1:0] r);
      bit got;
      @(posedge clk_i);
      awvalid_o <= 1'b1;
      awaddr_o  <= a;
      wvalid_o  <= 1'b1;
      wdata_o   <= d;
      wstrb_o   <= s;
      bready_o  <= 1'b1;
      got = 1'b0;
      // released payload shows inverse data, so stale values never look valid
      while (!got) begin
         @(posedge clk_i);
         if (awvalid_o && awready_i) begin
            awvalid_o <= 1'b0;
            awaddr_o  <= ~a;
         end
         if (wvalid_o && wready_i) begin
            wvalid_o <= 1'b0;
            wdata_o  <= ~d;
         end
         if (bvalid_i) begin
            got = 1'b1;
            r = bresp_i;
            bready_o <= 1'b0;
         end
      end
   endtask

   // single read, rready held until the data beat is seen
   task automatic rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
      bit got;
      @(posedge clk_i);
      arvalid_o <= 1'b1;
      araddr_o  <= a;
      rready_o  <= 1'b1;
      got = 1'b0;
      while (!got) begin
         @(posedge clk_i);
         if (arvalid_o && arready_i) begin
            arvalid_o <= 1'b0;
            araddr_o  <= ~a;
         end
         if (rvalid_i) begin
            got = 1'b1;
            d = rdata_i;
            r = rresp_i;
            rready_o <= 1'b0;
         end
      end
   endtask
endmodule // urd_link_model

// ---- testbench/urd_decoder_tb_top.sv ----
// testbench top: register-driven checks of the resistor enable decode
module urd_decoder_tb_top;
   import urd_pkg::*;
   timeunit 1ns;
   timeprecision 1ns;

   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic ce_i  = 1'b1;
   logic awv, awr, wv, wr_rdy, bv, br, arv, arr, rv, rr;
   logic [3:0] awa, ara, wst;
   logic [31:0] wd, rd;
   logic [1:0] bre, rre;
   urd_res_t res;
   int miscompares = 0;
   int checked = 0;
   int cycles = 0;
   logic [31:0] d;
   logic [1:0] r;

   ////////////////////////////////////////////////////////////////////////////
   // design and link model
   urd_decoder i_urd_decoder (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i),
      .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_awaddr(awa), .s_axi_wvalid(wv),
      .s_axi_wready(wr_rdy), .s_axi_wdata(wd), .s_axi_wstrb(wst), .s_axi_bvalid(bv),
      .s_axi_bready(br), .s_axi_bresp(bre), .s_axi_arvalid(arv), .s_axi_arready(arr),
      .s_axi_araddr(ara), .s_axi_rvalid(rv), .s_axi_rready(rr), .s_axi_rdata(rd),
      .s_axi_rresp(rre), .resistor_en_o(res));
   urd_link_model i_urd_link_model (.clk_i(clk_i), .awvalid_o(awv), .awready_i(awr),
      .awaddr_o(awa), .wvalid_o(wv), .wready_i(wr_rdy), .wdata_o(wd), .wstrb_o(wst),
      .bvalid_i(bv), .bready_o(br), .bresp_i(bre), .arvalid_o(arv), .arready_i(arr),
      .araddr_o(ara), .rvalid_i(rv), .rready_o(rr), .rdata_i(rd), .rresp_i(rre));

   // 50 ns clock
   initial begin
      forever #25 clk_i = ~clk_i;
   end

   // hang guard: the full sweep needs about a thousand cycles
   always @(posedge clk_i) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         miscompares++;
         end_of_test();
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         miscompares++;
         $display("Error %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   // reference decode, ctrl = {dm_req, dp_req, mode, term, select}
   function automatic logic [3:0] exp_res(input logic [6:0] c);
      logic drv;
      drv = (c[4:3] != 2'h1);
      return {(c[1:0] == 2'h0) & ~c[2] & drv,
              c[6] & drv,
              c[5] & drv,
              c[2] & ~c[5] & drv};
   endfunction

   // program ctrl, then check pins on the second falling edge after the write response, then status
   task automatic prog(input logic [6:0] c, input logic [3:0] e);
      i_urd_link_model.wr(URD_OFS_CTRL, {25'h0, c}, 4'hF, r);
      chk("bresp", {30'h0, r}, {30'h0, URD_RESP_OKAY});
      repeat (2) @(negedge clk_i);
      chk("resistor_en_o", {28'h0, res}, {28'h0, e});
      i_urd_link_model.rd(URD_OFS_STATUS, d, r);
      chk("status", d, {28'h0, e});
   endtask

   task automatic end_of_test();
      $display("checked %0d miscompares %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////////
   // main sequence
   initial begin
      repeat (16) @(posedge clk_i);
      rst_i <= 1'b0;
      @(negedge clk_i);
      chk("reset enables", {28'h0, res}, 32'h00000006);
      i_urd_link_model.rd(URD_OFS_CTRL, d, r);
      chk("reset ctrl", d, 32'h00000061);
      for (int i = 0; i < 128; i++) begin
         prog(i[6:0], exp_res(i[6:0]));
      end
      prog(7'h75, 4'h6);
      prog(7'h70, 4'hE);
      prog(7'h10, 4'h8);
      // lane 0 strobe off: ctrl must keep its value
      i_urd_link_model.wr(URD_OFS_CTRL, 32'h0000006F, 4'hE, r);
      i_urd_link_model.rd(URD_OFS_CTRL, d, r);
      chk("masked ctrl", d, 32'h00000010);
      // status is read-only
      i_urd_link_model.wr(URD_OFS_STATUS, 32'h00000000, 4'hF, r);
      chk("status wr resp", {30'h0, r}, {30'h0, URD_RESP_OKAY});
      i_urd_link_model.rd(URD_OFS_STATUS, d, r);
      chk("status kept", d, 32'h00000008);
      // unmapped places
      i_urd_link_model.wr(4'h8, 32'h00000000, 4'hF, r);
      chk("unmapped wr", {30'h0, r}, {30'h0, URD_RESP_SLVERR});
      i_urd_link_model.rd(4'h2, d, r);
      chk("unmapped rresp", {30'h0, r}, {30'h0, URD_RESP_SLVERR});
      chk("unmapped rdata", d, 32'h00000000);
      // mid-run reset taken while the clock enable is low, then frozen
      @(posedge clk_i);
      ce_i  <= 1'b0;
      rst_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      repeat (3) @(negedge clk_i);
      chk("frozen reset enables", {28'h0, res}, 32'h00000006);
      @(posedge clk_i);
      ce_i <= 1'b1;
      i_urd_link_model.rd(URD_OFS_CTRL, d, r);
      chk("reset ctrl again", d, 32'h00000061);
      end_of_test();
   end
endmodule // urd_decoder_tb_top
